// ### src/ccp_pkg.sv
package ccp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses and internal indices
   localparam logic [31:0] OFS_CONTROL = 32'h0000_0000;
   localparam logic [31:0] OFS_CAPTURE = 32'h0000_0004;
   localparam logic [31:0] OFS_LOW = 32'h0000_0008;
   localparam logic [31:0] OFS_HIGH = 32'h0000_000C;
   localparam logic [31:0] OFS_TSEL = 32'h0000_0010;
   localparam logic [2:0] IDX_CONTROL = 3'h0;
   localparam logic [2:0] IDX_CAPTURE = 3'h1;
   localparam logic [2:0] IDX_LOW = 3'h2;
   localparam logic [2:0] IDX_HIGH = 3'h3;
   localparam logic [2:0] IDX_TSEL = 3'h4;
   localparam logic [2:0] IDX_NONE = 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_OUT_BIT = 5;
   localparam int CTRL_FMT_BIT = 4;
   localparam int CHAN_TSEL_LSB = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Mode encodings
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_TOG_CLR = 4'h1;
   localparam logic [3:0] MODE_TOG = 4'h2;
   localparam logic [3:0] MODE_CAP_ANY = 4'h3;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_4 = 4'h6;
   localparam logic [3:0] MODE_CAP_16 = 4'h7;
   localparam logic [3:0] MODE_SET = 4'h8;
   localparam logic [3:0] MODE_CLR = 4'h9;
   localparam logic [3:0] MODE_PULSE = 4'hA;
   localparam logic [3:0] MODE_PULSE_CLR = 4'hB;
   localparam logic [3:0] MODE_PWM = 4'hF;
   localparam logic [1:0] TSEL_RESERVED = 2'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and prescaler counts
   localparam logic [7:0] TSEL_RESET = 8'h55;
   localparam logic [7:0] VALUE_RESET = 8'h00;
   localparam logic [3:0] PRESC_4_LAST = 4'h3;
   localparam logic [3:0] PRESC_16_LAST = 4'hF;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } wide_timer_s;

   typedef struct packed {
      logic [7:0] count;
      logic [1:0] phase;
      logic rollover;
   } narrow_tb_s;

   typedef struct packed {
      logic [3:0] logic_cell_result;
      logic pin_change_event;
      logic comparator_two_result;
      logic comparator_one_result;
   } trig_src_s;

   typedef struct packed {
      logic en;
      logic fmt;
      logic [3:0] mode;
      logic out;
      logic oe;
      logic [2:0] cts;
      logic [7:0] low;
      logic [7:0] high;
      logic [7:0] tsel;
      logic [9:0] duty;
      logic [3:0] presc;
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic src_prev;
      logic eq_prev;
      logic pulse;
      logic irq;
      logic adc;
      logic [2:0] tclr;
      logic wr_pend;
      logic rd_pend;
      logic [2:0] idx;
      logic [31:0] hrdata;
   } state_s;

   localparam state_s STATE_RESET = '{tsel: TSEL_RESET, default: '0};

endpackage : ccp_pkg

// ### src/ccp_capture_compare_pwm_ctrl.sv
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Reset returns all registers to reset values and releases the pin.
// - PWM time base is sampled on the system clock only.
// - Control bit 7 enables the channel.
// - Control bit 5 reads back the current output level.
// - Control bit 4 picks left or right width alignment in PWM.
// - Mode 0000 turns off and resets; 1111 is PWM; 1100-1110 reserved.
// - Capture on any, falling, rising, fourth or sixteenth rising edge.
// - Compare mode 1000 sets, 1001 clears output on match.
// - Mode 0010 toggles on match; 0001 also clears the wide timer.
// - Modes 1010/1011 emit one high pulse; 1011 also clears timer.
// - Every mode event flags interrupt and optional ADC trigger.
// - Capture source select: pin, comparators, pin change, logic cells.
// - Capture copies selected wide timer into low and high bytes.
// - Compare matches when both value bytes equal the timer bytes.
// - Right alignment: width is high[1:0] and low[7:0].
// - Left alignment: width is high[7:0] and low[7:6].
// - Two-bit timer select; 00 reserved selects no timer.
// - Timer select register holds four fields, each reset to 01.
// - Unimplemented bits read zero and ignore writes.
// - On rollover: set output unless width zero, reload width buffer.
// - PWM output clears when time base equals buffered width.
// - Width writes take effect only at the next rollover.
module ccp_capture_compare_pwm_ctrl (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   input wire ccp_pkg::trig_src_s trig_in,
   input wire ccp_pkg::wide_timer_s [2:0] wide_timers,
   output logic [2:0] wide_timer_clear,
   input wire ccp_pkg::narrow_tb_s [2:0] narrow_timers,
   input wire logic adc_source_sel,
   output logic channel_irq_flag,
   output logic adc_trigger
);

   ccp_pkg::state_s s_q;
   ccp_pkg::state_s s_d;
   logic [1:0] tsel;
   logic tsel_ok;
   logic [15:0] wide_val;
   ccp_pkg::narrow_tb_s nt;
   logic is_cmp;
   logic is_cap;
   logic is_pwm;
   logic active;
   logic cmp_eq;
   logic cmp_evt;
   logic src;
   logic rise;
   logic fall;
   logic [3:0] presc_last;
   logic cap_hit;
   logic cap_evt;
   logic pwm_evt;
   logic [9:0] width;
   logic [9:0] tbase;
   logic [7:0] src_raw;
   logic bus_take;

   ////////////////////////////////////////////////////////////////////////////
   // Decoders

   // Selected wide timer value; reserved select gives zero
   function automatic logic [15:0] wide_pick(
      input logic [1:0] sel,
      input ccp_pkg::wide_timer_s [2:0] t
   );
      logic [15:0] v;
      v = 16'h0000;
      if (sel != ccp_pkg::TSEL_RESERVED) begin
         v = {t[sel - 2'd1].high, t[sel - 2'd1].low};
      end
      return v;
   endfunction : wide_pick

   // Register index from byte address; anything else is unmapped
   function automatic logic [2:0] reg_idx(input logic [31:0] a);
      logic [2:0] r;
      r = ccp_pkg::IDX_NONE;
      case (a)
         ccp_pkg::OFS_CONTROL: r = ccp_pkg::IDX_CONTROL;
         ccp_pkg::OFS_CAPTURE: r = ccp_pkg::IDX_CAPTURE;
         ccp_pkg::OFS_LOW: r = ccp_pkg::IDX_LOW;
         ccp_pkg::OFS_HIGH: r = ccp_pkg::IDX_HIGH;
         ccp_pkg::OFS_TSEL: r = ccp_pkg::IDX_TSEL;
         default: r = ccp_pkg::IDX_NONE;
      endcase
      return r;
   endfunction : reg_idx

   ////////////////////////////////////////////////////////////////////////////
   // Mode classes and timer selection
   assign tsel = s_q.tsel[ccp_pkg::CHAN_TSEL_LSB +: 2];
   assign tsel_ok = (tsel != ccp_pkg::TSEL_RESERVED);
   assign wide_val = wide_pick(tsel, wide_timers);
   assign nt = tsel_ok ? narrow_timers[tsel - 2'd1] : '0;
   assign is_cmp = (s_q.mode == ccp_pkg::MODE_TOG_CLR) ||
                   (s_q.mode == ccp_pkg::MODE_TOG) ||
                   (s_q.mode[3:2] == 2'b10);
   assign is_cap = (s_q.mode >= ccp_pkg::MODE_CAP_ANY) &&
                   (s_q.mode <= ccp_pkg::MODE_CAP_16);
   assign is_pwm = (s_q.mode == ccp_pkg::MODE_PWM);
   assign active = s_q.en && (s_q.mode != ccp_pkg::MODE_OFF);

   // Compare match on both bytes, taken once per arrival
   assign cmp_eq = active && is_cmp && tsel_ok &&
                   (wide_val == {s_q.high, s_q.low});
   assign cmp_evt = cmp_eq && !s_q.eq_prev;

   // Source select over synchronised inputs, then edge detection
   assign src_raw = {trig_in.logic_cell_result, trig_in.pin_change_event,
                     trig_in.comparator_two_result,
                     trig_in.comparator_one_result, pin_in};
   assign src = s_q.sync2[s_q.cts];
   assign rise = src && !s_q.src_prev;
   assign fall = !src && s_q.src_prev;
   assign presc_last = (s_q.mode == ccp_pkg::MODE_CAP_4) ?
                       ccp_pkg::PRESC_4_LAST : ccp_pkg::PRESC_16_LAST;

   // Capture qualification per mode
   always_comb begin
      case (s_q.mode)
         ccp_pkg::MODE_CAP_ANY: cap_hit = rise || fall;
         ccp_pkg::MODE_CAP_FALL: cap_hit = fall;
         ccp_pkg::MODE_CAP_RISE: cap_hit = rise;
         ccp_pkg::MODE_CAP_4,
         ccp_pkg::MODE_CAP_16: cap_hit = rise && (s_q.presc == presc_last);
         default: cap_hit = 1'b0;
      endcase
   end
   assign cap_evt = active && cap_hit;

   // PWM width, time base and period event
   assign width = s_q.fmt ? {s_q.high, s_q.low[7:6]}
                          : {s_q.high[1:0], s_q.low};
   assign tbase = {nt.count, nt.phase};
   assign pwm_evt = active && is_pwm && tsel_ok && nt.rollover;
   assign bus_take = hsel && hready && htrans[1];

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.tclr = 3'b000;
      s_d.sync1 = src_raw;
      s_d.sync2 = s_q.sync1;
      s_d.src_prev = src;
      s_d.eq_prev = cmp_eq;
      if (!active) begin
         // Off or disabled: internal state back to rest
         s_d.out = 1'b0;
         s_d.presc = 4'h0;
         s_d.pulse = 1'b0;
      end else begin
         // Edge prescaler for the divided capture modes
         if (rise && ((s_q.mode == ccp_pkg::MODE_CAP_4) ||
                      (s_q.mode == ccp_pkg::MODE_CAP_16))) begin
            s_d.presc = (s_q.presc == presc_last) ? 4'h0
                                                  : s_q.presc + 4'h1;
         end
         if (cap_evt) begin
            s_d.low = wide_val[7:0];
            s_d.high = wide_val[15:8];
         end
         // Pulse modes return low one cycle after the match
         if (s_q.pulse) begin
            s_d.out = 1'b0;
            s_d.pulse = 1'b0;
         end
         if (cmp_evt) begin
            case (s_q.mode)
               ccp_pkg::MODE_SET: s_d.out = 1'b1;
               ccp_pkg::MODE_CLR: s_d.out = 1'b0;
               ccp_pkg::MODE_TOG: s_d.out = !s_q.out;
               ccp_pkg::MODE_TOG_CLR: begin
                  s_d.out = !s_q.out;
                  s_d.tclr[tsel - 2'd1] = 1'b1;
               end
               ccp_pkg::MODE_PULSE: begin
                  s_d.out = 1'b1;
                  s_d.pulse = 1'b1;
               end
               ccp_pkg::MODE_PULSE_CLR: begin
                  s_d.out = 1'b1;
                  s_d.pulse = 1'b1;
                  s_d.tclr[tsel - 2'd1] = 1'b1;
               end
               default: s_d.out = s_q.out;
            endcase
         end
         // PWM: reload and set at rollover, clear at width match
         if (is_pwm && tsel_ok) begin
            if (nt.rollover) begin
               s_d.duty = width;
               s_d.out = (width != 10'h000);
            end else if (tbase == s_q.duty) begin
               s_d.out = 1'b0;
            end
         end
      end
      s_d.irq = cmp_evt || cap_evt || pwm_evt;
      s_d.adc = (cmp_evt || cap_evt || pwm_evt) && adc_source_sel;
      s_d.oe = active && (is_cmp || is_pwm);

      // Register writes in the data phase; capture wins on value bytes
      s_d.wr_pend = 1'b0;
      s_d.rd_pend = 1'b0;
      if (s_q.wr_pend) begin
         case (s_q.idx)
            ccp_pkg::IDX_CONTROL: begin
               s_d.en = hwdata[ccp_pkg::CTRL_EN_BIT];
               s_d.fmt = hwdata[ccp_pkg::CTRL_FMT_BIT];
               s_d.mode = hwdata[3:0];
               if ((hwdata[3:0] != s_q.mode) ||
                   !hwdata[ccp_pkg::CTRL_EN_BIT]) begin
                  s_d.presc = 4'h0;
               end
            end
            ccp_pkg::IDX_CAPTURE: s_d.cts = hwdata[2:0];
            ccp_pkg::IDX_LOW: begin
               if (!cap_evt) begin
                  s_d.low = hwdata[7:0];
               end
            end
            ccp_pkg::IDX_HIGH: begin
               if (!cap_evt) begin
                  s_d.high = hwdata[7:0];
               end
            end
            ccp_pkg::IDX_TSEL: s_d.tsel = hwdata[7:0];
            default: s_d.tsel = s_q.tsel;
         endcase
      end
      // Read data loaded during the single wait cycle
      if (s_q.rd_pend) begin
         case (s_q.idx)
            ccp_pkg::IDX_CONTROL: s_d.hrdata = {24'h00_0000, s_q.en, 1'b0,
               s_q.out, s_q.fmt, s_q.mode};
            ccp_pkg::IDX_CAPTURE: s_d.hrdata = {29'h0000_0000, s_q.cts};
            ccp_pkg::IDX_LOW: s_d.hrdata = {24'h00_0000, s_q.low};
            ccp_pkg::IDX_HIGH: s_d.hrdata = {24'h00_0000, s_q.high};
            ccp_pkg::IDX_TSEL: s_d.hrdata = {24'h00_0000, s_q.tsel};
            default: s_d.hrdata = 32'h0000_0000;
         endcase
      end
      // Address phase capture
      if (bus_take) begin
         s_d.wr_pend = hwrite;
         s_d.rd_pend = !hwrite;
         s_d.idx = reg_idx(haddr);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= ccp_pkg::STATE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign hreadyout = !s_q.rd_pend;
   assign hresp = 1'b0;
   assign hrdata = s_q.hrdata;
   assign pin_out = s_q.out;
   assign pin_oe = s_q.oe;
   assign wide_timer_clear = s_q.tclr;
   assign channel_irq_flag = s_q.irq;
   assign adc_trigger = s_q.adc;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_capture_copy: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      cap_evt |=> ({s_q.high, s_q.low} == $past(wide_val)))
      else $error("capture did not copy the timer");

   a_compare_set: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      cmp_evt && (s_q.mode == ccp_pkg::MODE_SET) && !s_q.wr_pend
      |=> pin_out)
      else $error("set on match failed");

   a_compare_clear: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      cmp_evt && (s_q.mode == ccp_pkg::MODE_CLR) && !s_q.wr_pend
      |=> !pin_out)
      else $error("clear on match failed");

   a_toggle_match: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      cmp_evt && (s_q.mode == ccp_pkg::MODE_TOG) && !s_q.wr_pend
      |=> (pin_out != $past(pin_out)))
      else $error("toggle on match failed");

   a_pulse_shape: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      cmp_evt && (s_q.mode == ccp_pkg::MODE_PULSE) && !s_q.wr_pend
      |=> pin_out ##1 !pin_out)
      else $error("pulse shape wrong");

   a_timer_clear: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      cmp_evt && (s_q.mode == ccp_pkg::MODE_TOG_CLR)
      |=> (wide_timer_clear == (3'b001 << ($past(tsel) - 2'd1))))
      else $error("timer clear not issued");

   a_event_flag: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      (cmp_evt || cap_evt || pwm_evt) |=> channel_irq_flag ##1
      (!channel_irq_flag || $past(cmp_evt || cap_evt || pwm_evt)))
      else $error("event flag wrong");

   a_off_rest: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      !active && !s_q.wr_pend |=> !pin_out && (s_q.presc == 4'h0) && !pin_oe)
      else $error("off mode did not rest");

   a_pwm_reload: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      pwm_evt && !s_q.wr_pend
      |=> (s_q.duty == $past(width)) && (pin_out == ($past(width) != 0)))
      else $error("pwm reload wrong");

   a_read_wait: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      bus_take && !hwrite && (reg_idx(haddr) == ccp_pkg::IDX_CONTROL)
      |=> !hreadyout ##1 (hreadyout && (hrdata[31:8] == 24'h00_0000)
      && !hrdata[6]))
      else $error("control read wrong");

   a_width_hold: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      !pwm_evt |=> (s_q.duty == $past(s_q.duty)))
      else $error("width buffer changed off rollover");

endmodule : ccp_capture_compare_pwm_ctrl

// ### testbench/ccp_far_side_model.sv
`timescale 1ns/1ns

// Three wide timers and three narrow PWM time bases beside the channel
module ccp_far_side_model #(
   parameter logic [7:0] PWM_TOP = 8'h0F
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic run,
   input wire logic [2:0] wide_timer_clear,
   output ccp_pkg::wide_timer_s [2:0] wide_timers,
   output ccp_pkg::narrow_tb_s [2:0] narrow_timers
);

   logic [7:0] wide_cnt_q [3];
   logic [9:0] base_q;
   logic base_last;

   assign base_last = (base_q == {PWM_TOP, 2'h3});

   ////////////////////////////////////////////////////////////////////////////
   // Wide timers freeze when run is low; a clear pulse wins over counting
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         base_q <= 10'h000;
         for (int i = 0; i < 3; i++) wide_cnt_q[i] <= 8'h00;
      end else begin
         base_q <= base_last ? 10'h000 : base_q + 10'h001;
         for (int i = 0; i < 3; i++) begin
            if (wide_timer_clear[i]) wide_cnt_q[i] <= 8'h00;
            else if (run) wide_cnt_q[i] <= wide_cnt_q[i] + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // High byte tells the timers apart; time base is count and phase
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         wide_timers[i].high = 8'(8'h11 * i);
         wide_timers[i].low = wide_cnt_q[i];
         narrow_timers[i].count = base_q[9:2];
         narrow_timers[i].phase = base_q[1:0];
         narrow_timers[i].rollover = base_last;
      end
   end

endmodule : ccp_far_side_model

// ### testbench/ccp_capture_compare_pwm_ctrl_tb.sv
`timescale 1ns/1ns

module ccp_capture_compare_pwm_ctrl_tb;

   localparam logic [7:0] PWM_TOP = 8'h0F;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic tmr_run = 1'b0;
   logic adc_sel = 1'b0;
   logic [7:0] src_v = 8'h00;
   logic hreadyout, hresp, pin_out, pin_oe, irq, adc, rdy_s;
   logic [31:0] hrdata, rd_s;
   logic [2:0] tmr_clr;
   ccp_pkg::wide_timer_s [2:0] wide_tmr;
   ccp_pkg::narrow_tb_s [2:0] narrow_tmr;
   int num_errors = 0;
   int samples_checked = 0;
   int irq_cnt = 0;
   int adc_cnt = 0;

   always #20 sys_clk = ~sys_clk;

   ccp_capture_compare_pwm_ctrl u_ccp_capture_compare_pwm_ctrl (
      .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .pin_in(src_v[0]), .pin_out(pin_out),
      .pin_oe(pin_oe), .trig_in(ccp_pkg::trig_src_s'(src_v[7:1])),
      .wide_timers(wide_tmr), .wide_timer_clear(tmr_clr),
      .narrow_timers(narrow_tmr), .adc_source_sel(adc_sel),
      .channel_irq_flag(irq), .adc_trigger(adc));

   ccp_far_side_model #(.PWM_TOP(PWM_TOP)) u_ccp_far_side_model (
      .sys_clk(sys_clk), .nrst(nrst), .run(tmr_run),
      .wide_timer_clear(tmr_clr), .wide_timers(wide_tmr),
      .narrow_timers(narrow_tmr));

   ////////////////////////////////////////////////////////////////////////////
   // Bus answer taken mid-cycle so the master's edge sees settled values
   always @(negedge sys_clk) begin
      rdy_s <= hreadyout;
      rd_s <= hrdata;
   end

   // Event counters for the capture scenarios
   always @(posedge sys_clk) begin
      if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
      if (adc === 1'b1) adc_cnt <= adc_cnt + 1;
   end

   task automatic test_done();
      if (num_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   // Hang guard, well beyond the expected run
   initial begin
      repeat (40000) @(posedge sys_clk);
      num_errors++;
      test_done();
   end

   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   ////////////////////////////////////////////////////////////////////////////
   // Single word transfers; address held until the slave is ready
   task automatic bus_xfer(input logic [31:0] a, input logic wr,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge sys_clk); while (rdy_s !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (rdy_s !== 1'b1);
      q = rd_s;
   endtask : bus_xfer

   task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus_xfer(a, 1'b1, d, q);
   endtask : bus_write

   task automatic read_check(input logic [31:0] a, input logic [31:0] e,
      input string what);
      logic [31:0] q;
      bus_xfer(a, 1'b0, 32'h0000_0000, q);
      check(what, q, e);
   endtask : read_check

   ////////////////////////////////////////////////////////////////////////////
   task automatic reset_values();
      read_check(ccp_pkg::OFS_CONTROL, 32'h0000_0000, "control");
      read_check(ccp_pkg::OFS_CAPTURE, 32'h0000_0000, "capture");
      read_check(ccp_pkg::OFS_LOW, 32'h0000_0000, "low byte");
      read_check(ccp_pkg::OFS_HIGH, 32'h0000_0000, "high byte");
      read_check(ccp_pkg::OFS_TSEL, 32'h0000_0055, "timer sel");
      read_check(32'h0000_0014, 32'h0000_0000, "unmapped");
      check("pin enable", 32'(pin_oe), 32'h0000_0000);
      check("response", 32'(hresp), 32'h0000_0000);
   endtask : reset_values

   task automatic reg_access();
      bus_write(ccp_pkg::OFS_CONTROL, 32'h0000_005C);
      read_check(ccp_pkg::OFS_CONTROL, 32'h0000_001C, "control");
      bus_write(ccp_pkg::OFS_CAPTURE, 32'h0000_00FF);
      read_check(ccp_pkg::OFS_CAPTURE, 32'h0000_0007, "capture");
      bus_write(ccp_pkg::OFS_HIGH, 32'h0000_005A);
      read_check(ccp_pkg::OFS_HIGH, 32'h0000_005A, "high byte");
      bus_write(ccp_pkg::OFS_TSEL, 32'h0000_00E4);
      read_check(ccp_pkg::OFS_TSEL, 32'h0000_00E4, "timer sel");
      bus_write(32'h0000_0014, 32'h0000_00FF);
      read_check(32'h0000_0014, 32'h0000_0000, "unmapped");
      bus_write(ccp_pkg::OFS_TSEL, 32'h0000_0055);
   endtask : reg_access

   task automatic wait_irq();
      int n = 0;
      @(negedge sys_clk);
      while (irq !== 1'b1 && n < 600) begin
         @(negedge sys_clk);
         n++;
      end
      check("event seen", 32'(irq), 32'h0000_0001);
   endtask : wait_irq

   // Every compare mode in turn against a running wide timer
   task automatic compare_modes();
      logic [3:0] md [7] = '{4'h8, 4'h9, 4'h2, 4'h2, 4'h1, 4'hA, 4'hB};
      logic [6:0] out_e = 7'h75;
      logic [6:0] clr_e = 7'h50;
      tmr_run <= 1'b1;
      bus_write(ccp_pkg::OFS_LOW, 32'h0000_0040);
      bus_write(ccp_pkg::OFS_HIGH, 32'h0000_0000);
      for (int i = 0; i < 7; i++) begin
         bus_write(ccp_pkg::OFS_CONTROL, {24'h00_0000, 4'h8, md[i]});
         wait_irq();
         check("match out", 32'(pin_out), 32'(out_e[i]));
         check("timer clear", 32'(tmr_clr[0]), 32'(clr_e[i]));
         check("pin enable", 32'(pin_oe), 32'h0000_0001);
         if (md[i][3:1] == 3'h5) begin
            @(negedge sys_clk);
            check("pulse end", 32'(pin_out), 32'h0000_0000);
         end
         if (i == 0) begin
            read_check(ccp_pkg::OFS_CONTROL, 32'h0000_00A8, "out");
         end
      end
   endtask : compare_modes

   task automatic pulse_src(input int k, input int n);
      repeat (n) begin
         @(posedge sys_clk);
         src_v[k] <= 1'b1;
         repeat (4) @(posedge sys_clk);
         src_v[k] <= 1'b0;
         repeat (3) @(posedge sys_clk);
      end
      repeat (10) @(posedge sys_clk);
   endtask : pulse_src

   // Capture edge modes, trigger sources and the captured timer value
   task automatic capture_modes();
      logic [3:0] md [5] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
      int exp [5] = '{32, 16, 16, 4, 1};
      int i0 = 0;
      int a0 = 0;
      @(posedge sys_clk);
      tmr_run <= 1'b0;
      adc_sel <= 1'b1;
      bus_write(ccp_pkg::OFS_TSEL, 32'h0000_0056);
      bus_write(ccp_pkg::OFS_CAPTURE, 32'h0000_0000);
      for (int i = 0; i < 5; i++) begin
         bus_write(ccp_pkg::OFS_CONTROL, {24'h00_0000, 4'h8, md[i]});
         @(negedge sys_clk);
         i0 = irq_cnt;
         a0 = adc_cnt;
         pulse_src(0, 16);
         i0 = irq_cnt - i0;
         a0 = adc_cnt - a0;
         check("captures", 32'(i0), 32'(exp[i]));
         check("adc triggers", 32'(a0), 32'(exp[i]));
      end
      check("pin enable", 32'(pin_oe), 32'h0000_0000);
      read_check(ccp_pkg::OFS_LOW, 32'(wide_tmr[1].low), "cap low");
      read_check(ccp_pkg::OFS_HIGH, 32'(wide_tmr[1].high), "cap hi");
      adc_sel <= 1'b0;
      bus_write(ccp_pkg::OFS_CONTROL, 32'h0000_0085);
      for (int k = 1; k < 8; k++) begin
         bus_write(ccp_pkg::OFS_CAPTURE, 32'(k));
         @(negedge sys_clk);
         i0 = irq_cnt;
         a0 = adc_cnt;
         pulse_src(k, 1);
         i0 = irq_cnt - i0;
         a0 = adc_cnt - a0;
         check("source", 32'(i0 + 2 * a0), 32'h0000_0001);
      end
   endtask : capture_modes

   // High time of one full PWM period, after the new width is latched
   task automatic pwm_width(input logic [7:0] lo, input logic [7:0] hi,
      input logic [7:0] ctl, input int exp);
      int n = 0;
      bus_write(ccp_pkg::OFS_LOW, 32'(lo));
      bus_write(ccp_pkg::OFS_HIGH, 32'(hi));
      bus_write(ccp_pkg::OFS_CONTROL, 32'(ctl));
      repeat (2) begin
         n = 0;
         @(negedge sys_clk);
         while (narrow_tmr[0].rollover !== 1'b1) @(negedge sys_clk);
         repeat (4 * (int'(PWM_TOP) + 1)) begin
            @(negedge sys_clk);
            if (pin_out === 1'b1) n++;
         end
      end
      check("pwm high", 32'(n), 32'(exp));
   endtask : pwm_width

   // Reserved mode drops the pin enable, mode off also rests the output
   task automatic off_mode();
      @(negedge sys_clk);
      while (narrow_tmr[0].rollover !== 1'b1) @(negedge sys_clk);
      bus_write(ccp_pkg::OFS_CONTROL, 32'h0000_008C);
      repeat (2) @(negedge sys_clk);
      check("reserved enable", 32'(pin_oe), 32'h0000_0000);
      bus_write(ccp_pkg::OFS_CONTROL, 32'h0000_0080);
      repeat (2) @(negedge sys_clk);
      check("off out", 32'(pin_out), 32'h0000_0000);
      check("off enable", 32'(pin_oe), 32'h0000_0000);
      read_check(ccp_pkg::OFS_CONTROL, 32'h0000_0080, "off ctl");
   endtask : off_mode

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      reset_values();
      reg_access();
      compare_modes();
      capture_modes();
      pwm_width(8'h10, 8'hFC, 8'h8F, 17);
      pwm_width(8'h7F, 8'h04, 8'h9F, 18);
      off_mode();
      pwm_width(8'h00, 8'h00, 8'h8F, 0);
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      reset_values();
      test_done();
   end

endmodule : ccp_capture_compare_pwm_ctrl_tb
